/* File: include/cpqos_pkg.sv */
// Constants, register map and carrier types for the cache partition QoS block
package cpqos_pkg;
    localparam int COS_NUM = 16;
    localparam int COS_W = 4;
    localparam int CBM_LEN = 16;
    localparam logic [15:0] COS_MAX_CAP = 16'h000f;
    localparam logic [15:0] COS_MAX_ALL = 16'h000f;
    localparam logic [COS_W-1:0] COS_RESET = 4'h0;
    localparam logic [CBM_LEN-1:0] CBM_ALL_ONES = 16'hffff;
    localparam logic [CBM_LEN-1:0] CBM_OTHER_RESET = 16'hffff;
    localparam int FIELD_HI_LSB = 32;
    // APB byte addresses
    localparam logic [11:0] ADDR_ASSOC_LO = 12'h000;
    localparam logic [11:0] ADDR_ASSOC_HI = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
    localparam logic [11:0] ADDR_CTRL = 12'h010;
    localparam logic [11:0] ADDR_CAP = 12'h014;
    localparam logic [11:0] ADDR_ASSOC_PUB = 12'h018;
    localparam logic [11:0] ADDR_MASK_BASE = 12'h100;
    localparam logic [11:0] ADDR_MASK_END = 12'h4ff;
    localparam logic [7:0] MASK_INDEX_MAX = 8'hff;
    // Status / mask / control bit positions
    localparam int ST_GP_RSVD = 0;
    localparam int ST_GP_RANGE = 1;
    localparam int ST_GP_COS = 2;
    localparam int ST_W = 3;
    localparam int CTRL_IDLE = 0;
    localparam int CTRL_SMI = 1;
    localparam int CTRL_PWR_SHRINK = 2;

    typedef struct packed {
        logic fill_req;
        logic [CBM_LEN-1:0] busy_units;
    } cpqos_fill_req_t;

    typedef struct packed {
        logic fill_grant;
        logic [CBM_LEN-1:0] victim_onehot;
        logic [COS_W-1:0] fill_cos;
    } cpqos_fill_rsp_t;

    typedef enum logic [1:0] {
        CPQOS_ACTIVE = 2'b00,
        CPQOS_IDLE = 2'b01,
        CPQOS_RESUME = 2'b11
    } cpqos_pwr_t;
endpackage

/* File: rtl/cpqos_victim_sel.sv */
// Victim picker restricted to allowed allocation units
`timescale 1ns/100ps
`default_nettype none
module cpqos_victim_sel
    import cpqos_pkg::*;
(
    input wire logic [CBM_LEN-1:0] allow, // Units allowed for this class
    input wire logic [CBM_LEN-1:0] busy, // Units unable to take a fill
    input wire logic [CBM_LEN-1:0] rr_ptr, // One-hot rotation start
    output logic [CBM_LEN-1:0] victim, // One-hot chosen unit
    output logic found // A unit was chosen
);
    logic [CBM_LEN-1:0] cand;
    logic [2*CBM_LEN-1:0] dbl;
    logic [2*CBM_LEN-1:0] pick2;
    logic [2*CBM_LEN-1:0] seen;

    assign cand = allow & ~busy;
    // Doubled copy lets the scan wrap past the top unit once
    assign dbl = {cand, cand};

    // First candidate at or after the rotation pointer, wrapping once
    genvar i;
    generate
        for (i = 0; i < 2*CBM_LEN; i++) begin : g_scan
            if (i == 0) begin : g_first
                assign pick2[i] = dbl[i] & rr_ptr[0];
                assign seen[i] = pick2[i];
            end else begin : g_rest
                logic in_win;
                assign in_win = (i >= CBM_LEN) ? 1'b1 : |(rr_ptr & ((1 << (i + 1)) - 1));
                assign pick2[i] = dbl[i] & in_win & ~seen[i-1];
                assign seen[i] = seen[i-1] | pick2[i];
            end
        end
    endgenerate

    assign victim = pick2[CBM_LEN-1:0] | pick2[2*CBM_LEN-1:CBM_LEN];
    assign found = |cand;
endmodule
`default_nettype wire

/* File: rtl/cpqos_regs.sv */
// Cache partition QoS registers, fault checks and fill steering
// Functional notes
// (RQ1) Both register kinds are readable and writable at any time.
// (RQ2) Write touching a reserved bit faults and changes nothing.
// (RQ3) Mask register index above the supported maximum class faults.
// (RQ4) Writing class above largest supported maximum faults.
// (RQ5) Association read returns the current class.
// (RQ6) Mask register n read returns class n bitmask.
// (RQ7) Power shrink may override bitmasks for affected cache.
// (RQ8) After resume, new fills obey the requesting class bitmask.
// (RQ9) Lines from before shrink need not stay resident.
// (RQ10) Association saved at deep core idle entry, restored at exit.
// (RQ11) Mask contents survive package idle states.
// (RQ12) Management interrupt delivery leaves all registers untouched.
// (RQ13) Partitioning steers placement only, never coherency.
// (RQ14) Class field is zero after power-on.
// (RQ15) Class zero mask is all ones after reset.
// (RQ16) Class number sits in bits 63:32 of association register.
// (RQ17) Victims are chosen only among units set in class mask.
// (RQ18) Faulting write changes nothing; good write governs later fills.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module cpqos_regs
    import cpqos_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error, the protection fault
    input wire logic core_idle_req, // Deep core idle entry level
    input wire logic pwr_shrink, // Cache portions shrunk or off
    input wire logic smi_active, // Management interrupt in service
    input wire cpqos_fill_req_t fill_req, // Fill request in
    output cpqos_fill_rsp_t fill_rsp, // Fill victim out
    output logic flush_on_idle, // Write back lines on idle entry
    output logic irq // Unmasked fault status pending
);
    logic [COS_W-1:0] cos_reg;
    logic [COS_W-1:0] cos_save_reg;
    logic [CBM_LEN-1:0] cbm_reg [COS_NUM];
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] irq_mask_reg;
    logic [CBM_LEN-1:0] rr_reg;
    cpqos_pwr_t pwr_reg;
    cpqos_pwr_t pwr_next;
    cpqos_fill_rsp_t rsp_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire sel_lo = (paddr == ADDR_ASSOC_LO);
    wire sel_hi = (paddr == ADDR_ASSOC_HI);
    wire sel_st = (paddr == ADDR_STATUS);
    wire sel_im = (paddr == ADDR_IRQ_MASK);
    wire sel_cap = (paddr == ADDR_CAP);
    wire sel_pub = (paddr == ADDR_ASSOC_PUB);
    wire sel_msk = (paddr >= ADDR_MASK_BASE) && (paddr <= ADDR_MASK_END) && (paddr[1:0] == 2'b00);
    wire [11:0] moff = paddr - ADDR_MASK_BASE;
    wire [7:0] midx = moff[9:2];
    wire [COS_W-1:0] cidx = midx[COS_W-1:0];
    wire mapped = sel_lo | sel_hi | sel_st | sel_im | sel_cap | sel_pub | sel_msk;
    wire [31:0] wdat = pwdata;

    // Fault decided in the setup cycle so pslverr stands through access
    wire setup = psel & ~penable;
    // (RQ3) mask index beyond max class
    wire gp_range = sel_msk && ({8'h00, midx} > COS_MAX_CAP);
    // (RQ2) reserved bits changed
    wire gp_rsvd = pwrite && ((sel_lo && wdat != 32'h0)
        || (sel_msk && !gp_range && wdat[31:CBM_LEN] != 16'h0)
        || (sel_hi && wdat[31:16] != 16'h0 && wdat[15:0] <= COS_MAX_ALL));
    // (RQ4) class above largest maximum
    wire gp_cos = pwrite && sel_hi && (wdat[31:16] != 16'h0 || wdat[15:0] > COS_MAX_ALL);
    wire gp_ro = pwrite && (sel_cap || sel_pub);
    wire gp_any = gp_range || gp_rsvd || gp_cos || !mapped || gp_ro;
    wire fault = acc && gp_any;
    // (RQ18) only clean writes commit
    wire wr_ok = wr && !fault;

    // (RQ5) (RQ6) (RQ16) read mux
    wire [31:0] rd_val = sel_hi ? {{(32-COS_W){1'b0}}, cos_reg}
        : sel_st ? {{(32-ST_W){1'b0}}, status_reg}
        : sel_im ? {{(32-ST_W){1'b0}}, irq_mask_reg}
        : sel_cap ? {16'h0, COS_MAX_CAP}
        : sel_pub ? {{(32-COS_W){1'b0}}, cos_reg}
        : (sel_msk && !gp_range) ? {{(32-CBM_LEN){1'b0}}, cbm_reg[cidx]}
        : 32'h0;

    // (RQ1) zero wait, always ready
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= (psel & ~penable & ~pwrite) ? rd_val : prdata_reg;
            pslverr_reg <= setup ? gp_any : pslverr_reg;
        end
    end

    // Deep idle sequencing
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            CPQOS_ACTIVE: if (core_idle_req) pwr_next = CPQOS_IDLE;
            CPQOS_IDLE: if (!core_idle_req) pwr_next = CPQOS_RESUME;
            CPQOS_RESUME: pwr_next = CPQOS_ACTIVE;
            default: pwr_next = CPQOS_ACTIVE;
        endcase
    end

    wire idle_enter = (pwr_reg == CPQOS_ACTIVE) && core_idle_req;
    wire idle_exit = (pwr_reg == CPQOS_RESUME);
    // (RQ9) flush allowed while entering idle
    assign flush_on_idle = (pwr_reg == CPQOS_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= CPQOS_ACTIVE;
            cos_save_reg <= COS_RESET;
        end else begin
            pwr_reg <= pwr_next;
            // (RQ10) save on idle entry
            cos_save_reg <= idle_enter ? cos_reg : cos_save_reg;
        end
    end

    // (RQ14) (RQ12) class reset, untouched by management interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cos_reg <= COS_RESET;
        end else if (idle_exit) begin
            // (RQ10) restore on exit
            cos_reg <= cos_save_reg;
        end else if (wr_ok && sel_hi) begin
            cos_reg <= wdat[COS_W-1:0];
        end
    end

    // (RQ11) (RQ15) masks kept across idle, class zero all ones
    genvar g;
    generate
        for (g = 0; g < COS_NUM; g++) begin : g_cbm
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cbm_reg[g] <= (g == 0) ? CBM_ALL_ONES : CBM_OTHER_RESET;
                end else if (wr_ok && sel_msk && cidx == COS_W'(g)) begin
                    cbm_reg[g] <= wdat[CBM_LEN-1:0];
                end
            end
        end
    endgenerate

    // Fault events; set wins over write-one-to-clear
    wire [ST_W-1:0] ev = {acc & gp_cos, acc & gp_range, acc & (gp_rsvd | !mapped | gp_ro)};
    wire [ST_W-1:0] clr = (wr && sel_st) ? wdat[ST_W-1:0] : {ST_W{1'b0}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= {ST_W{1'b0}};
            irq_mask_reg <= {ST_W{1'b0}};
        end else begin
            status_reg <= (status_reg & ~clr) | ev;
            irq_mask_reg <= (wr && sel_im) ? wdat[ST_W-1:0] : irq_mask_reg;
        end
    end
    assign irq = |(status_reg & irq_mask_reg);

    // (RQ7) power feature takes precedence
    wire [CBM_LEN-1:0] allow = pwr_shrink ? CBM_ALL_ONES : cbm_reg[cos_reg];
    wire [CBM_LEN-1:0] victim;
    wire found;

    // (RQ17) (RQ8) victim within class mask, or any unit while pwr_shrink
    cpqos_victim_sel u_vsel (
        .allow(allow),
        .busy(fill_req.busy_units),
        .rr_ptr(rr_reg),
        .victim(victim),
        .found(found)
    );

    // (RQ13) placement only; no coherency action here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_reg <= '0;
            rr_reg <= {{(CBM_LEN-1){1'b0}}, 1'b1};
        end else begin
            rsp_reg.fill_grant <= fill_req.fill_req & found & (pwr_reg != CPQOS_IDLE);
            rsp_reg.victim_onehot <= (fill_req.fill_req & found) ? victim : {CBM_LEN{1'b0}};
            rsp_reg.fill_cos <= cos_reg;
            rr_reg <= (fill_req.fill_req & found) ? {rr_reg[CBM_LEN-2:0], rr_reg[CBM_LEN-1]} : rr_reg;
        end
    end
    assign fill_rsp = rsp_reg;
endmodule
`default_nettype wire

/* File: sim/cpqos_regs_monitor.sv */
// Concurrent checks on the cache partition QoS register block ports
`timescale 1ns/100ps
`default_nettype none
module cpqos_regs_monitor
    import cpqos_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Read data
    input wire logic pslverr, // Fault
    input wire logic core_idle_req, // Idle level
    input wire cpqos_fill_req_t fill_req, // Fill request
    input wire cpqos_fill_rsp_t fill_rsp, // Fill answer
    input wire logic flush_on_idle // Idle flush
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic setup_w = psel && !penable && pwrite;
    wire logic setup_r = psel && !penable && !pwrite;
    // Index 16 upward is beyond the supported classes
    wire logic hi_idx = paddr >= ADDR_MASK_BASE + 12'h040 && paddr <= ADDR_MASK_END;
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access not ready");
    property p_gp_rsvd; setup_w && paddr == ADDR_ASSOC_LO && pwdata != 32'h0 |=> pslverr; endproperty
    a_gp_rsvd: assert property (p_gp_rsvd) else $error("low word write not refused");
    property p_gp_bits; setup_w && paddr == ADDR_MASK_BASE && pwdata[31:16] != 16'h0 |=> pslverr; endproperty
    a_gp_bits: assert property (p_gp_bits) else $error("mask upper bits not refused");
    property p_gp_range; psel && !penable && hi_idx |=> pslverr; endproperty
    a_gp_range: assert property (p_gp_range) else $error("mask index not refused");
    property p_gp_cos; setup_w && paddr == ADDR_ASSOC_HI && pwdata > 32'(COS_MAX_ALL) |=> pslverr; endproperty
    a_gp_cos: assert property (p_gp_cos) else $error("class too high not refused");
    property p_ok_cos; setup_w && paddr == ADDR_ASSOC_HI && pwdata <= 32'(COS_MAX_ALL) |=> !pslverr; endproperty
    a_ok_cos: assert property (p_ok_cos) else $error("legal class refused");
    property p_cap; setup_r && paddr == ADDR_CAP |=> prdata == 32'(COS_MAX_CAP); endproperty
    a_cap: assert property (p_cap) else $error("capability read wrong");
    property p_fill;
        fill_rsp.fill_grant |-> $past(fill_req.fill_req) && $onehot(fill_rsp.victim_onehot)
            && (fill_rsp.victim_onehot & $past(fill_req.busy_units)) == 16'h0000;
    endproperty
    a_fill: assert property (p_fill) else $error("bad victim grant");
    property p_idle; $rose(core_idle_req) |-> ##[1:3] flush_on_idle; endproperty
    a_idle: assert property (p_idle) else $error("no flush on idle entry");
endmodule
bind cpqos_regs cpqos_regs_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_idle_req(core_idle_req), .fill_req(fill_req), .fill_rsp(fill_rsp), .flush_on_idle(flush_on_idle));
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the cache partition QoS register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top import cpqos_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic core_idle_req = 1'b0, pwr_shrink = 1'b0, smi_active = 1'b0;
    logic pready, pslverr, flush_on_idle, irq, er;
    cpqos_fill_req_t fill_req = '0;
    cpqos_fill_rsp_t fill_rsp;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #2 pclk = ~pclk;
    cpqos_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .core_idle_req(core_idle_req), .pwr_shrink(pwr_shrink), .smi_active(smi_active),
        .fill_req(fill_req), .fill_rsp(fill_rsp), .flush_on_idle(flush_on_idle), .irq(irq));
    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    // Read data is compared only on reads that are not refused
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("pslverr", ee, er)
        if (!w && !ee) `CHK("prdata", d, rd)
    endtask
    task automatic fill(input logic [15:0] busy, input logic g, input logic [15:0] ok);
        @(posedge pclk);
        fill_req <= '{1'b1, busy};
        @(posedge pclk);
        fill_req <= '0;
        #1;
        `CHK("grant", g, fill_rsp.fill_grant)
        if (g) begin
            `CHK("victim", 1'b1, $onehot(fill_rsp.victim_onehot & ok & ~busy))
            `CHK("fill_cos", 4'h5, fill_rsp.fill_cos)
        end
    endtask
    task automatic t_reset();
        acc(1'b0, ADDR_ASSOC_HI, 32'h0, 1'b0);
        acc(1'b0, ADDR_MASK_BASE, 32'h0000ffff, 1'b0);
        acc(1'b0, ADDR_CAP, 32'h0000000f, 1'b0);
    endtask
    task automatic t_assoc();
        acc(1'b1, ADDR_ASSOC_HI, 32'h5, 1'b0);
        acc(1'b0, ADDR_ASSOC_HI, 32'h5, 1'b0);
        acc(1'b0, ADDR_ASSOC_LO, 32'h0, 1'b0);
        acc(1'b1, ADDR_ASSOC_LO, 32'h1, 1'b1);
        acc(1'b1, ADDR_ASSOC_HI, 32'h10, 1'b1);
        acc(1'b0, ADDR_ASSOC_HI, 32'h5, 1'b0);
    endtask
    task automatic t_mask();
        for (int n = 0; n < 16; n++) acc(1'b1, ADDR_MASK_BASE + 12'(4 * n), 32'h00f0 ^ n, 1'b0);
        for (int n = 0; n < 16; n++) acc(1'b0, ADDR_MASK_BASE + 12'(4 * n), 32'h00f0 ^ n, 1'b0);
        acc(1'b1, ADDR_MASK_BASE + 12'h014, 32'h10000, 1'b1);
        acc(1'b0, ADDR_MASK_BASE + 12'h014, 32'h00f5, 1'b0);
        acc(1'b0, ADDR_MASK_BASE + 12'h040, 32'h0, 1'b1);
        acc(1'b1, ADDR_MASK_END - 12'h003, 32'h1, 1'b1);
        acc(1'b0, 12'h050, 32'h0, 1'b1);
    endtask
    task automatic t_irq();
        acc(1'b0, ADDR_STATUS, 32'h7, 1'b0);
        #1 `CHK("irq masked", 1'b0, irq)
        acc(1'b1, ADDR_IRQ_MASK, 32'h7, 1'b0);
        #1 `CHK("irq raised", 1'b1, irq)
        acc(1'b1, ADDR_STATUS, 32'h7, 1'b0);
        #1 `CHK("irq cleared", 1'b0, irq)
        acc(1'b1, ADDR_IRQ_MASK, 32'h0, 1'b0);
        acc(1'b0, ADDR_STATUS, 32'h0, 1'b0);
    endtask
    task automatic t_fill();
        fill(16'h0000, 1'b1, 16'h00f5);
        fill(16'h00f5, 1'b0, 16'h00f5);
        pwr_shrink <= 1'b1;
        fill(16'h00f5, 1'b1, 16'hffff);
        pwr_shrink <= 1'b0;
    endtask
    // Idle entry with a management interrupt under way
    task automatic t_idle();
        core_idle_req <= 1'b1;
        smi_active <= 1'b1;
        repeat (3) @(posedge pclk);
        #1 `CHK("flush_on_idle", 1'b1, flush_on_idle)
        fill(16'h0000, 1'b0, 16'h00f5);
        acc(1'b1, ADDR_ASSOC_HI, 32'h3, 1'b0);
        core_idle_req <= 1'b0;
        smi_active <= 1'b0;
        repeat (3) @(posedge pclk);
        acc(1'b0, ADDR_ASSOC_HI, 32'h5, 1'b0);
        acc(1'b0, ADDR_MASK_BASE + 12'h014, 32'h00f5, 1'b0);
        acc(1'b0, ADDR_MASK_BASE, 32'h00f0, 1'b0);
        fill(16'h0000, 1'b1, 16'h00f5);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_assoc();
        t_mask();
        t_irq();
        t_fill();
        t_idle();
        end_of_test();
    end
endmodule
`default_nettype wire
